// ===== design/mbac_params.svh
// Constants for the mode based access control block.
`ifndef MBAC_PARAMS_SVH
`define MBAC_PARAMS_SVH
// Register byte offsets on the AXI4-Lite bus.
`define MBAC_OFF_CTRL      12'h000
`define MBAC_OFF_STATUS    12'h004
`define MBAC_OFF_VADDR     12'h008
`define MBAC_OFF_ROMCRD    12'h010
`define MBAC_OFF_ROMREF    12'h014
`define MBAC_OFF_RAMCRD    12'h018
`define MBAC_OFF_PARTSZ    12'h01c
`define MBAC_OFF_SELFTEST  12'h020
`define MBAC_OFF_UNMAPPED  12'h00c
`define MBAC_OFF_OWN_BASE  12'h040
`define MBAC_OFF_SEG_BASE  12'h080
// Counts and field positions.
`define MBAC_NUM_PERIPH    4
`define MBAC_NUM_SEG       8
`define MBAC_SEG_IDX_W     3
`define MBAC_PER_IDX_W     2
`define MBAC_MODE_W        3
// Segment descriptor fields: [31:20] base page, [19:8] limit page, [7] valid,
// [6] code, [5:3] owner mode, [2:0] shared mode; all three share bits are compared.
`define MBAC_SEG_VALID     7
`define MBAC_SEG_CODE      6
`define MBAC_SEG_OWN_LSB   3
`define MBAC_SEG_SHR_LSB   0
`define MBAC_SEG_BASE_LSB  20
`define MBAC_SEG_LIM_LSB   8
`define MBAC_PAGE_W        12
// Reset values.
`define MBAC_RST_WORD      32'h0000_0000
`define MBAC_RST_OWNER     3'h0
// AXI responses.
`define MBAC_RESP_OKAY     2'h0
`define MBAC_RESP_SLVERR   2'h2
`endif

// ===== design/mbac_pkg.sv
// Types for the mode based access control block.
package mbac_pkg;
	// Privilege modes; super system mode is code 0 and is the reset owner.
	typedef enum logic [2:0] {
		MBAC_SUPER_SYS = 3'h0,
		MBAC_TEST      = 3'h1,
		MBAC_CONFIG    = 3'h2,
		MBAC_SYS_A     = 3'h3,
		MBAC_USER_A    = 3'h4,
		MBAC_SYS_B     = 3'h5,
		MBAC_USER_B    = 3'h6,
		MBAC_NONE      = 3'h7
	} mbac_mode_t;
	// Core access target class.
	typedef enum logic [1:0] {
		MBAC_TGT_MEM   = 2'h0,
		MBAC_TGT_PERIPH = 2'h1,
		MBAC_TGT_SFR   = 2'h2
	} mbac_target_t;
endpackage : mbac_pkg

// ===== design/mbac_seg_match.sv
// Segment descriptor lookup: finds the descriptor that covers a virtual page.
`timescale 1ns/100ps
`include "mbac_params.svh"
module mbac_seg_match
	import mbac_pkg::*;
(
	// Descriptor table, flattened.
	input  wire logic [`MBAC_NUM_SEG*32-1:0] segTable,
	// Lookup request.
	input  wire logic [31:0]                 vaddr,
	// Lookup result.
	output logic                             hit,
	output logic [31:0]                      desc
);
	logic [`MBAC_NUM_SEG-1:0] matchVec;
	// One comparator per descriptor.
	genvar g;
	generate
		for (g = 0; g < `MBAC_NUM_SEG; g++) begin : gen_cmp
			wire logic [31:0] d = segTable[g*32 +: 32];
			wire logic [`MBAC_PAGE_W-1:0] pg = vaddr[31 -: `MBAC_PAGE_W];
			assign matchVec[g] = d[`MBAC_SEG_VALID]
				&& (pg >= d[`MBAC_SEG_BASE_LSB +: `MBAC_PAGE_W])
				&& (pg <= d[`MBAC_SEG_LIM_LSB +: `MBAC_PAGE_W]);
		end
	endgenerate
	// Lowest matching descriptor wins.
	always_comb begin
		hit = 1'b0;
		desc = `MBAC_RST_WORD;
		for (int i = `MBAC_NUM_SEG - 1; i >= 0; i--) begin
			if (matchVec[i]) begin
				hit = 1'b1;
				desc = segTable[i*32 +: 32];
			end
		end
	end
endmodule : mbac_seg_match

// ===== design/mbac_access_ctrl.sv
// Mode based access control top: core check port plus AXI4-Lite register slave.
// Function
// - Self-test SFR content read and written only from configuration or test mode.
// - Foreign-owned segments usable only when the owner shares them with current mode.
// - Crypto, RNG, comms and timer usable only by the recorded owner mode.
// - No access crosses between card A and card B system or user modes.
// - Both ROM card configuration registers ignore writes in every mode.
// - Descriptors and ownership change only from a mode with write access there.
// - Reset gives every peripheral owner field super system mode.
// - No input can override the restrictive reset values.
// - Any denied access raises the security reset request.
// - A mode may access segments it owns itself.
// - Missing descriptor for a code fetch raises a code miss exception.
// - Card configuration SFR writes only from test or configuration mode.
`timescale 1ns/100ps
`include "mbac_params.svh"
module mbac_access_ctrl
	import mbac_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        clkEn,
	// Core access check.
	input  wire logic        accValid,
	input  wire logic        accWrite,
	input  wire logic        accFetch,
	input  wire logic [1:0]  accTarget,
	input  wire logic [2:0]  accMode,
	input  wire logic [31:0] accAddr,
	output logic             accGrant,
	output logic             accDeny,
	output logic             codeMiss,
	output logic             securityReset,
	// AXI4-Lite write address and data.
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response.
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read.
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Mode of the code issuing the bus access, from the core.
	input  wire logic [2:0]  busMode
);
	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic [31:0] ctrl_reg, romCardCfgFirst_reg, romRefCfgFirst_reg;
	logic [31:0] ramCardCfgFirst_reg, partSizeCfg_reg, selfTest_reg;
	logic [31:0] violAddr_reg;
	logic [2:0]  violCount_reg;
	logic        violSticky_reg, missSticky_reg;
	logic [`MBAC_NUM_PERIPH*3-1:0] periphOwner_reg;
	logic [`MBAC_NUM_SEG*32-1:0]   segTable_reg;
	logic        awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg;
	logic [11:0] awAddr_reg;
	logic [31:0] wData_reg, rdata_reg;
	logic [3:0]  wStrb_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic        accGrant_reg, accDeny_reg, codeMiss_reg, secRst_reg, busDeny;

	// ------------------------------------------------------------------
	// Mode classes
	// ------------------------------------------------------------------
	function automatic logic isPriv(input logic [2:0] m);
		isPriv = (m == MBAC_TEST) || (m == MBAC_CONFIG);
	endfunction : isPriv
	function automatic logic isSuper(input logic [2:0] m);
		isSuper = (m == MBAC_SUPER_SYS) || isPriv(m);
	endfunction : isSuper
	function automatic logic isCardA(input logic [2:0] m);
		isCardA = (m == MBAC_SYS_A) || (m == MBAC_USER_A);
	endfunction : isCardA
	function automatic logic isCardB(input logic [2:0] m);
		isCardB = (m == MBAC_SYS_B) || (m == MBAC_USER_B);
	endfunction : isCardB

	// ------------------------------------------------------------------
	// Core access decision
	// ------------------------------------------------------------------
	wire logic        segHit;
	wire logic [31:0] segDesc;
	mbac_seg_match u_seg (
		.segTable (segTable_reg),
		.vaddr    (accAddr),
		.hit      (segHit),
		.desc     (segDesc)
	);
	wire logic [2:0] segOwner  = segDesc[`MBAC_SEG_OWN_LSB +: 3];
	wire logic [2:0] segShare  = segDesc[`MBAC_SEG_SHR_LSB +: 3];
	wire logic       crossCard = (isCardA(accMode) && isCardB(segOwner))
		|| (isCardB(accMode) && isCardA(segOwner));
	wire logic       ownSeg    = segHit && (segOwner == accMode);
	wire logic       sharedSeg = segHit && (segShare == accMode) && !crossCard;
	wire logic       memOk     = (ownSeg || sharedSeg) && !crossCard;
	wire logic       fetchMiss = accFetch && !segHit;
	wire logic [`MBAC_PER_IDX_W-1:0] perIdx = accAddr[`MBAC_PER_IDX_W-1:0];
	wire logic [2:0] perOwner  = periphOwner_reg[perIdx*3 +: 3];
	wire logic       perOk     = (perOwner == accMode);
	wire logic       sfrOk     = isPriv(accMode);
	wire logic       grantNow  = (accTarget == MBAC_TGT_MEM)    ? memOk :
		(accTarget == MBAC_TGT_PERIPH) ? perOk :
		(accTarget == MBAC_TGT_SFR)    ? sfrOk : 1'b0;
	wire logic       denyNow   = accValid && !grantNow && !fetchMiss;

	// Registered decision; the core must not commit until accGrant is seen.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			accGrant_reg <= 1'b0;
			accDeny_reg  <= 1'b0;
			codeMiss_reg <= 1'b0;
			secRst_reg   <= 1'b0;
		end else if (clkEn) begin
			accGrant_reg <= accValid && grantNow && !fetchMiss;
			accDeny_reg  <= denyNow;
			codeMiss_reg <= accValid && fetchMiss;
			secRst_reg   <= denyNow || busDeny;
		end
	end
	assign accGrant      = accGrant_reg;
	assign accDeny       = accDeny_reg;
	assign codeMiss      = codeMiss_reg;
	assign securityReset = secRst_reg;

	// ------------------------------------------------------------------
	// AXI4-Lite decode
	// ------------------------------------------------------------------
	wire logic       wrFire  = awHeld_reg && wHeld_reg && !bvalid_reg;
	wire logic       rdFire  = s_axi_arvalid && !rvalid_reg;
	wire logic [11:0] wa     = awAddr_reg;
	wire logic [11:0] ra     = s_axi_araddr;
	wire logic       wOwnHit = (wa[11:6] == `MBAC_OFF_OWN_BASE >> 6)
		&& (wa[5:2] < `MBAC_NUM_PERIPH);
	wire logic       wSegHit = (wa[11:7] == `MBAC_OFF_SEG_BASE >> 7);
	wire logic       rOwnHit = (ra[11:6] == `MBAC_OFF_OWN_BASE >> 6)
		&& (ra[5:2] < `MBAC_NUM_PERIPH);
	wire logic       rSegHit = (ra[11:7] == `MBAC_OFF_SEG_BASE >> 7);
	wire logic [`MBAC_PER_IDX_W-1:0] wPer = wa[2 +: `MBAC_PER_IDX_W];
	wire logic [`MBAC_SEG_IDX_W-1:0] wSeg = wa[2 +: `MBAC_SEG_IDX_W];
	wire logic [`MBAC_PER_IDX_W-1:0] rPer = ra[2 +: `MBAC_PER_IDX_W];
	wire logic [`MBAC_SEG_IDX_W-1:0] rSeg = ra[2 +: `MBAC_SEG_IDX_W];
	// Security attribute tables are writable only from super system modes.
	wire logic       attrWrOk = isSuper(busMode);
	wire logic       cfgWrOk  = isPriv(busMode);
	wire logic       wMapped  = (wa == `MBAC_OFF_CTRL) || (wa == `MBAC_OFF_STATUS)
		|| (wa == `MBAC_OFF_ROMCRD) || (wa == `MBAC_OFF_ROMREF)
		|| (wa == `MBAC_OFF_RAMCRD) || (wa == `MBAC_OFF_PARTSZ)
		|| (wa == `MBAC_OFF_SELFTEST) || wOwnHit || wSegHit;
	wire logic       wAllowed =
		(wa == `MBAC_OFF_CTRL)     ? attrWrOk :
		(wa == `MBAC_OFF_STATUS)   ? attrWrOk :
		(wa == `MBAC_OFF_RAMCRD)   ? cfgWrOk :
		(wa == `MBAC_OFF_PARTSZ)   ? cfgWrOk :
		(wa == `MBAC_OFF_SELFTEST) ? cfgWrOk :
		(wOwnHit || wSegHit)       ? attrWrOk : 1'b0;  // ROM words never.
	wire logic       rAllowed =
		((ra == `MBAC_OFF_ROMCRD) || (ra == `MBAC_OFF_ROMREF) || (ra == `MBAC_OFF_RAMCRD)
		|| (ra == `MBAC_OFF_PARTSZ)) ? (isSuper(busMode) || (busMode == MBAC_SYS_A)
		|| (busMode == MBAC_SYS_B)) :
		(ra == `MBAC_OFF_SELFTEST) ? isPriv(busMode) :
		1'b1;
	wire logic       doWrite  = wrFire && wMapped && wAllowed;
	assign busDeny = clkEn && ((wrFire && wMapped && !wAllowed)
		|| (rdFire && !rAllowed));
	wire logic [31:0] wMask   = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
		{8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
	wire logic [31:0] statusWord = {violAddr_reg[15:0], 11'h000, violCount_reg,
		missSticky_reg, violSticky_reg};
	wire logic [31:0] rWord =
		(ra == `MBAC_OFF_CTRL)     ? ctrl_reg :
		(ra == `MBAC_OFF_STATUS)   ? statusWord :
		(ra == `MBAC_OFF_VADDR)    ? violAddr_reg :
		(ra == `MBAC_OFF_ROMCRD)   ? romCardCfgFirst_reg :
		(ra == `MBAC_OFF_ROMREF)   ? romRefCfgFirst_reg :
		(ra == `MBAC_OFF_RAMCRD)   ? ramCardCfgFirst_reg :
		(ra == `MBAC_OFF_PARTSZ)   ? partSizeCfg_reg :
		(ra == `MBAC_OFF_SELFTEST) ? selfTest_reg :
		rOwnHit ? {29'h0000_0000, periphOwner_reg[rPer*3 +: 3]} :
		rSegHit ? segTable_reg[rSeg*32 +: 32] : `MBAC_RST_WORD;
	wire logic       rMapped  = (ra <= `MBAC_OFF_SELFTEST) && (ra != `MBAC_OFF_UNMAPPED)
		|| rOwnHit || rSegHit;

	// ------------------------------------------------------------------
	// AXI4-Lite handshake
	// ------------------------------------------------------------------
	assign s_axi_awready = !awHeld_reg;
	assign s_axi_wready  = !wHeld_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// Channel holding and responses.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			awAddr_reg <= 12'h000;
			wData_reg  <= `MBAC_RST_WORD;
			wStrb_reg  <= 4'h0;
			bresp_reg  <= `MBAC_RESP_OKAY;
			rresp_reg  <= `MBAC_RESP_OKAY;
			rdata_reg  <= `MBAC_RST_WORD;
		end else if (clkEn) begin
			if (s_axi_awvalid && !awHeld_reg) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && !wHeld_reg) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (wrFire) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= (wMapped && wAllowed) ? `MBAC_RESP_OKAY : `MBAC_RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				awHeld_reg <= 1'b0;
				wHeld_reg  <= 1'b0;
			end
			if (rdFire) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= (rMapped && rAllowed) ? rWord : `MBAC_RST_WORD;
				rresp_reg  <= (rMapped && rAllowed) ? `MBAC_RESP_OKAY : `MBAC_RESP_SLVERR;
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Register writes; reset values are constants only.
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_reg            <= `MBAC_RST_WORD;
			romCardCfgFirst_reg <= `MBAC_RST_WORD;
			romRefCfgFirst_reg  <= `MBAC_RST_WORD;
			ramCardCfgFirst_reg <= `MBAC_RST_WORD;
			partSizeCfg_reg     <= `MBAC_RST_WORD;
			selfTest_reg        <= `MBAC_RST_WORD;
			periphOwner_reg     <= {`MBAC_NUM_PERIPH{`MBAC_RST_OWNER}};
			segTable_reg        <= {`MBAC_NUM_SEG{`MBAC_RST_WORD}};
		end else if (clkEn && doWrite) begin
			if (wa == `MBAC_OFF_CTRL)
				ctrl_reg <= (ctrl_reg & ~wMask) | (wData_reg & wMask);
			if (wa == `MBAC_OFF_RAMCRD)
				ramCardCfgFirst_reg <= (ramCardCfgFirst_reg & ~wMask) | (wData_reg & wMask);
			if (wa == `MBAC_OFF_PARTSZ)
				partSizeCfg_reg <= (partSizeCfg_reg & ~wMask) | (wData_reg & wMask);
			if (wa == `MBAC_OFF_SELFTEST)
				selfTest_reg <= (selfTest_reg & ~wMask) | (wData_reg & wMask);
			if (wOwnHit && wStrb_reg[0])
				periphOwner_reg[wPer*3 +: 3] <= wData_reg[2:0];
			if (wSegHit)
				segTable_reg[wSeg*32 +: 32] <= (segTable_reg[wSeg*32 +: 32] & ~wMask)
					| (wData_reg & wMask);
		end
	end

	// Violation status; a new event wins over a status write that clears.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			violSticky_reg <= 1'b0;
			missSticky_reg <= 1'b0;
			violCount_reg  <= 3'h0;
			violAddr_reg   <= `MBAC_RST_WORD;
		end else if (clkEn) begin
			if (doWrite && (wa == `MBAC_OFF_STATUS)) begin
				violSticky_reg <= violSticky_reg & ~wData_reg[0];
				missSticky_reg <= missSticky_reg & ~wData_reg[1];
			end
			if (denyNow || busDeny) begin
				violSticky_reg <= 1'b1;
				violCount_reg  <= violCount_reg + 3'h1;
				violAddr_reg   <= denyNow ? accAddr : {20'h00000, wrFire ? wa : ra};
			end
			if (accValid && fetchMiss)
				missSticky_reg <= 1'b1;
		end
	end
endmodule : mbac_access_ctrl

// ===== tb/mbac_access_ctrl_asserts.sv
// Checker for the core check port and register bus of the access control block.
`timescale 1ns/100ps
`include "mbac_params.svh"
module mbac_chk (
	// Clock, reset and enable.
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        clkEn,
	// Core access check.
	input wire logic        accValid,
	input wire logic        accFetch,
	input wire logic [1:0]  accTarget,
	input wire logic [2:0]  accMode,
	input wire logic        accGrant,
	input wire logic        accDeny,
	input wire logic        codeMiss,
	input wire logic        securityReset,
	// Register bus.
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [2:0]  busMode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic ownTouched;
	logic romPend;
	wire  awHs = s_axi_awvalid && s_axi_awready;
	wire  accTake = accValid && clkEn;
	// Remembers any owner write attempt and a pending write to a ROM word.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ownTouched <= 1'b0;
			romPend    <= 1'b0;
		end else begin
			if (awHs && s_axi_awaddr[11:4] == 8'h04) ownTouched <= 1'b1;
			if (awHs && (s_axi_awaddr == `MBAC_OFF_ROMCRD || s_axi_awaddr == `MBAC_OFF_ROMREF))
				romPend <= 1'b1;
			else if (s_axi_bvalid && s_axi_bready) romPend <= 1'b0;
		end
	end
	AST_ONE_ANSWER: assert property (accTake |=> $onehot({accGrant, accDeny, codeMiss}))
		else $error("Core request without exactly one answer.");
	AST_IDLE_QUIET: assert property (clkEn && !accValid |=> !(accGrant || accDeny || codeMiss))
		else $error("Core answer without a request.");
	AST_DENY_RESETS: assert property (accDeny |-> securityReset)
		else $error("Denied access without security reset.");
	AST_BAD_TARGET: assert property (accTake && !accFetch && accTarget == 2'h3 |=> accDeny)
		else $error("Reserved target not denied.");
	AST_MISS_FETCH: assert property (codeMiss |-> $past(accFetch) && !securityReset)
		else $error("Code miss without a fetch.");
	AST_PERIPH_DEFAULT: assert property (accTake && accTarget == 2'h1 && accMode != 3'h0 &&
		!ownTouched |=> accDeny)
		else $error("Peripheral granted to a mode other than the reset owner.");
	AST_ROM_REFUSED: assert property (s_axi_bvalid && romPend |-> s_axi_bresp == 2'h2)
		else $error("ROM configuration write accepted.");
	AST_B_LATENCY: assert property (awHs && s_axi_wvalid && s_axi_wready |=>
		!s_axi_bvalid ##1 s_axi_bvalid)
		else $error("Write response late or early.");
	AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read data not returned next cycle.");
	AST_SELFTEST_READ: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == `MBAC_OFF_SELFTEST && !(busMode inside {3'h1, 3'h2}) |=>
		s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0 && securityReset)
		else $error("Self-test content read from a barred mode.");
endmodule : mbac_chk

bind mbac_access_ctrl mbac_chk u_chk (.ref_clk, .srst, .clkEn, .accValid, .accFetch, .accTarget,
	.accMode, .accGrant, .accDeny, .codeMiss, .securityReset, .s_axi_awvalid, .s_axi_awready,
	.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
	.busMode);

// ===== tb/mbac_core_model.sv
// Processor core model issuing one mode-tagged access per command pulse.
`timescale 1ns/100ps
module mbac_core_model (
	// Clock.
	input wire logic         ref_clk,
	// Command from the bench.
	input wire logic         go,
	input wire logic         fetch,
	input wire logic [1:0]   tgt,
	input wire logic [2:0]   mode,
	input wire logic [31:0]  addr,
	// Core access request.
	output logic             accValid = 1'b0,
	output logic             accWrite = 1'b0,
	output logic             accFetch = 1'b0,
	output logic [1:0]       accTarget = 2'h0,
	output logic [2:0]       accMode = 3'h0,
	output logic [31:0]      accAddr = 32'h0
);
	// Target, mode and address are inverted while idle so no stale request can look valid.
	always_ff @(posedge ref_clk) begin
		accValid  <= go;
		accWrite  <= 1'b0;
		accFetch  <= go & fetch;
		accTarget <= go ? tgt : ~accTarget;
		accMode   <= go ? mode : ~accMode;
		accAddr   <= go ? addr : ~accAddr;
	end
endmodule : mbac_core_model

// ===== tb/tb_top.sv
// Self-checking testbench for the mode based access control block.
`timescale 1ns/100ps
`include "mbac_params.svh"
module tb_top;
	localparam logic [3:0]  G = 4'b1000, D = 4'b0101, M = 4'b0010;
	localparam logic [1:0]  OK = `MBAC_RESP_OKAY, ER = `MBAC_RESP_SLVERR;
	localparam logic [31:0] SEG = 32'h0010_0000;
	// Clock, reset and core command.
	logic        ref_clk = 1'b0, srst = 1'b1, go = 1'b0, cmdFetch = 1'b0;
	logic [1:0]  cmdTgt = 2'h0;
	logic [2:0]  cmdMode = 3'h0, busMode = 3'h0;
	logic [31:0] cmdAddr = 32'h0, s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	// Design outputs and core wires.
	logic        accValid, accWrite, accFetch, accGrant, accDeny, codeMiss, securityReset;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  accTarget, s_axi_bresp, s_axi_rresp;
	logic [2:0]  accMode;
	logic [31:0] accAddr, s_axi_rdata;
	int          num_errors = 0, checked = 0;

	// Clock of 5 ns period.
	always #2.5 ref_clk = ~ref_clk;

	mbac_core_model u_core (.ref_clk, .go, .fetch(cmdFetch), .tgt(cmdTgt), .mode(cmdMode),
		.addr(cmdAddr), .accValid, .accWrite, .accFetch, .accTarget, .accMode, .accAddr);
	mbac_access_ctrl DUT (.ref_clk, .srst, .clkEn(1'b1), .accValid, .accWrite, .accFetch,
		.accTarget, .accMode, .accAddr, .accGrant, .accDeny, .codeMiss, .securityReset,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .busMode);

	// Builds a valid data descriptor covering page 0x001.
	function automatic logic [31:0] desc(input logic [2:0] o, input logic [2:0] s);
		return {12'h001, 12'h001, 1'b1, 1'b0, o, s};
	endfunction : desc

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task automatic hang;
		num_errors++;
		$display("ERROR %0t: bus wait timed out", $time);
		end_sim();
	endtask : hang

	task automatic do_reset;
		srst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
	endtask : do_reset

	// Bus write; handshakes are judged on the values standing before each edge.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [2:0] m,
		input logic [1:0] er);
		logic aw, w, b;
		int   n;
		b = 1'b0;
		n = 0;
		@(posedge ref_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_bready  <= 1'b1;
		busMode       <= m;
		while (!b && n < 50) begin
			@(negedge ref_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			n++;
			if (b) chk(32'(s_axi_bresp), 32'(er));
			@(posedge ref_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (!b) hang();
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [2:0] m, input logic [1:0] er,
		input logic [31:0] ed);
		logic ar, r;
		int   n;
		r = 1'b0;
		n = 0;
		@(posedge ref_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		busMode       <= m;
		while (!r && n < 50) begin
			@(negedge ref_clk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			n++;
			if (r) chk({s_axi_rdata[31:2], s_axi_rresp}, {ed[31:2], er});
			if (r) chk(s_axi_rdata, ed);
			@(posedge ref_clk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (!r) hang();
	endtask : rd

	// One core access; the answer stands one cycle after the model presents it.
	task automatic core(input logic [2:0] m, input logic [1:0] t, input logic [31:0] a,
		input logic f, input logic [3:0] e);
		@(posedge ref_clk);
		go       <= 1'b1;
		cmdMode  <= m;
		cmdTgt   <= t;
		cmdAddr  <= a;
		cmdFetch <= f;
		@(posedge ref_clk);
		go <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'({accGrant, accDeny, codeMiss, securityReset}), 32'(e));
	endtask : core

	task automatic t_defaults;
		rd(12'h044, 3'h0, OK, 32'h0);
		rd(12'h080, 3'h0, OK, 32'h0);
		rd(12'h004, 3'h0, OK, 32'h0);
		rd(12'h008, 3'h0, OK, 32'h0);
		core(3'h3, 2'h1, 32'h1, 1'b0, D);
		core(3'h3, 2'h0, SEG, 1'b0, D);
		$display("t_defaults finished");
	endtask : t_defaults

	task automatic t_segments;
		wr(12'h080, desc(3'h3, 3'h7), 3'h4, ER);
		core(3'h3, 2'h0, SEG, 1'b0, D);
		wr(12'h080, desc(3'h3, 3'h7), 3'h0, OK);
		core(3'h3, 2'h0, SEG, 1'b0, G);
		core(3'h4, 2'h0, SEG, 1'b0, D);
		wr(12'h080, desc(3'h3, 3'h4), 3'h0, OK);
		core(3'h4, 2'h0, SEG, 1'b0, G);
		wr(12'h080, desc(3'h3, 3'h6), 3'h0, OK);
		core(3'h6, 2'h0, SEG, 1'b0, D);
		core(3'h5, 2'h0, SEG, 1'b0, D);
		core(3'h3, 2'h0, 32'h0500_0000, 1'b1, M);
		core(3'h3, 2'h3, SEG, 1'b0, D);
		$display("t_segments finished");
	endtask : t_segments

	task automatic t_periph;
		wr(12'h044, 32'h3, 3'h4, ER);
		rd(12'h044, 3'h0, OK, 32'h0);
		wr(12'h044, 32'h3, 3'h0, OK);
		for (int p = 0; p < 4; p++) core(3'h3, 2'h1, 32'(p), 1'b0, (p == 1) ? G : D);
		core(3'h4, 2'h1, 32'h1, 1'b0, D);
		$display("t_periph finished");
	endtask : t_periph

	task automatic t_sfr;
		wr(12'h010, 32'h5a, 3'h1, ER);
		wr(12'h014, 32'h5a, 3'h2, ER);
		rd(12'h010, 3'h0, OK, 32'h0);
		rd(12'h014, 3'h3, OK, 32'h0);
		wr(12'h020, 32'h1234, 3'h3, ER);
		wr(12'h020, 32'h1234, 3'h1, OK);
		rd(12'h020, 3'h2, OK, 32'h1234);
		rd(12'h020, 3'h0, ER, 32'h0);
		wr(12'h018, 32'h77, 3'h0, ER);
		wr(12'h018, 32'h77, 3'h2, OK);
		rd(12'h018, 3'h5, OK, 32'h77);
		rd(12'h018, 3'h4, ER, 32'h0);
		rd(12'h00c, 3'h0, ER, 32'h0);
		$display("t_sfr finished");
	endtask : t_sfr

	// Main sequence; a second reset shows the restrictive values return.
	initial begin
		do_reset();
		t_defaults();
		t_segments();
		t_periph();
		t_sfr();
		do_reset();
		t_defaults();
		end_sim();
	end
endmodule : tb_top
